// file: jtap_pin_if.sv
// sampled test pins and clock edges passed from synchroniser to controller
`timescale 1ns/1ps
interface jtap_pin_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic trst_act;

  modport src (output tck_rise, output tck_fall, output tms, output tdi, output trst_act);
  modport dst (input tck_rise, input tck_fall, input tms, input tdi, input trst_act);
endinterface

// file: jtap_pkg.sv
// shared constants and types for the test access port block
package jtap_pkg;

  // tap controller states, standard binary codes
  typedef enum logic [3:0] {
    JTAP_EXIT2_DR  = 4'h0,
    JTAP_EXIT1_DR  = 4'h1,
    JTAP_SHIFT_DR  = 4'h2,
    JTAP_PAUSE_DR  = 4'h3,
    JTAP_SEL_IR    = 4'h4,
    JTAP_UPDATE_DR = 4'h5,
    JTAP_CAPT_DR   = 4'h6,
    JTAP_SEL_DR    = 4'h7,
    JTAP_EXIT2_IR  = 4'h8,
    JTAP_EXIT1_IR  = 4'h9,
    JTAP_SHIFT_IR  = 4'hA,
    JTAP_PAUSE_IR  = 4'hB,
    JTAP_IDLE      = 4'hC,
    JTAP_UPDATE_IR = 4'hD,
    JTAP_CAPT_IR   = 4'hE,
    JTAP_TLR       = 4'hF
  } jtap_state_t;

  // instruction register layout
  localparam int          JTAP_IR_W       = 4;
  localparam int          JTAP_DR_W       = 32;
  localparam logic [3:0]  JTAP_IR_CAPTURE = 4'h1;
  localparam logic [3:0]  JTAP_IR_IDCODE  = 4'h1;
  localparam logic [3:0]  JTAP_IR_BYPASS  = 4'hF;
  // identification word, value arbitrary, lsb must be one
  localparam logic [31:0] JTAP_IDCODE_VAL = 32'h1234_5001;
  localparam logic [31:0] JTAP_DR_ZERO    = 32'h0000_0000;
  localparam logic [3:0]  JTAP_IR_ZERO    = 4'h0;
  localparam int          JTAP_DR_MSB     = 31;
  localparam int          JTAP_IR_MSB     = 3;
  localparam int          JTAP_SYNC_LEN   = 2;

endpackage

// file: jtap_probe.sv
// behavioural test controller on the far side of the pins
`timescale 1ns/1ps
module jtap_probe (
  // pins driven
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  // pins read
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // tck rests low between frames; test reset held after power-up
  initial begin
    {tck, tms, tdi, trst_n} = 4'h6;
    #200 trst_n = 1'b1;
  end
  // one tck period: pins move while tck low, tdo taken at the rise
  task automatic step(input logic m, input logic d, output logic q, output logic o);
    {tms, tdi} = {m, d};
    #62.5 tck = 1'b1;
    // a released tdo has no pull-up: show the inverse so a stale bit cannot pass
    {q, o} = {tdo_oe ? tdo : ~tdo, tdo_oe};
    #62.5 tck = 1'b0;
  endtask
  // test reset level, set only while tck rests low
  task automatic set_reset(input logic v);
    trst_n = v;
  endtask
endmodule // jtap_probe

// file: jtap_sync.sv
// two-stage synchronisers for the test pins and test clock edge finder
`timescale 1ns/1ps
module jtap_sync
  import jtap_pkg::*;
(
  // system clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw pins from the probe
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic trst_n,
  // sampled view
  jtap_pin_if.src   pins
);

  logic [3:0] s1_reg;
  logic [3:0] s1_next;
  logic [3:0] s2_reg;
  logic [3:0] s2_next;
  logic       tck_d_reg;
  logic       tck_d_next;

  // reset image of the pins: tck rests low with no pull-up, the others are pulled high;
  // a reset value off the idle level would fake a tck edge right after reset
  localparam logic [3:0] PIN_IDLE = 4'hE;

  // first stage feeds only the second; pull-ups make idle pins other than tck read high
  always_comb begin
    s1_next    = {trst_n, tdi, tms, tck};
    s2_next    = s1_reg;
    tck_d_next = s2_reg[0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg    <= PIN_IDLE;
      s2_reg    <= PIN_IDLE;
      tck_d_reg <= PIN_IDLE[0];
    end else begin
      s1_reg    <= s1_next;
      s2_reg    <= s2_next;
      tck_d_reg <= tck_d_next;
    end
  end

  // edges are found on the settled copy only
  assign pins.tck_rise = s2_reg[0] & ~tck_d_reg;
  assign pins.tck_fall = ~s2_reg[0] & tck_d_reg;
  assign pins.tms      = s2_reg[1];
  assign pins.tdi      = s2_reg[2];
  assign pins.trst_act = ~s2_reg[3];

endmodule // jtap_sync

// file: jtap_tap.sv
// test access port controller with instruction, bypass and id registers
`timescale 1ns/1ps
// Overview of operation
// - four-wire port plus optional reset, standard sixteen-state controller
// - test data input captured on rising test clock edges in shift-IR and shift-DR only
// - mode select sampled on rising test clock edge, steps controller
// - data output enabled only in shift-IR and shift-DR, else released
// - data output changes only on falling test clock edges, except that test reset releases it at once
// - test reset initialises controller at once, no test clock needed
module jtap_tap
  import jtap_pkg::*;
(
  // system clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // test port pins
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic trst_n,
  // test data output, three-state
  output logic      tdo,
  output logic      tdo_oe,
  // controller status
  output logic      tlr_state
);

  jtap_pin_if pins ();

  jtap_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .tck    (tck),
    .tms    (tms),
    .tdi    (tdi),
    .trst_n (trst_n),
    .pins   (pins)
  );

  // standard state transition on the sampled mode select
  function automatic jtap_state_t next_state(input jtap_state_t s, input logic m);
    unique case (s)
      JTAP_TLR:       next_state = m ? JTAP_TLR      : JTAP_IDLE;
      JTAP_IDLE:      next_state = m ? JTAP_SEL_DR   : JTAP_IDLE;
      JTAP_SEL_DR:    next_state = m ? JTAP_SEL_IR   : JTAP_CAPT_DR;
      JTAP_CAPT_DR:   next_state = m ? JTAP_EXIT1_DR : JTAP_SHIFT_DR;
      JTAP_SHIFT_DR:  next_state = m ? JTAP_EXIT1_DR : JTAP_SHIFT_DR;
      JTAP_EXIT1_DR:  next_state = m ? JTAP_UPDATE_DR : JTAP_PAUSE_DR;
      JTAP_PAUSE_DR:  next_state = m ? JTAP_EXIT2_DR : JTAP_PAUSE_DR;
      JTAP_EXIT2_DR:  next_state = m ? JTAP_UPDATE_DR : JTAP_SHIFT_DR;
      JTAP_UPDATE_DR: next_state = m ? JTAP_SEL_DR   : JTAP_IDLE;
      JTAP_SEL_IR:    next_state = m ? JTAP_TLR      : JTAP_CAPT_IR;
      JTAP_CAPT_IR:   next_state = m ? JTAP_EXIT1_IR : JTAP_SHIFT_IR;
      JTAP_SHIFT_IR:  next_state = m ? JTAP_EXIT1_IR : JTAP_SHIFT_IR;
      JTAP_EXIT1_IR:  next_state = m ? JTAP_UPDATE_IR : JTAP_PAUSE_IR;
      JTAP_PAUSE_IR:  next_state = m ? JTAP_EXIT2_IR : JTAP_PAUSE_IR;
      JTAP_EXIT2_IR:  next_state = m ? JTAP_UPDATE_IR : JTAP_SHIFT_IR;
      JTAP_UPDATE_IR: next_state = m ? JTAP_SEL_DR   : JTAP_IDLE;
    endcase
  endfunction

  // a shift state is the only time the output pin is driven
  function automatic logic is_shift(input jtap_state_t s);
    is_shift = (s == JTAP_SHIFT_DR) || (s == JTAP_SHIFT_IR);
  endfunction

  jtap_state_t          state_reg;
  jtap_state_t          state_next;
  logic [JTAP_IR_W-1:0] ir_reg;
  logic [JTAP_IR_W-1:0] ir_next;
  logic [JTAP_IR_W-1:0] irsh_reg;
  logic [JTAP_IR_W-1:0] irsh_next;
  logic [JTAP_DR_W-1:0] drsh_reg;
  logic [JTAP_DR_W-1:0] drsh_next;
  logic                 tdo_reg;
  logic                 tdo_next;
  logic                 oe_reg;
  logic                 oe_next;
  logic                 tlr_reg;
  logic                 tlr_next;
  logic                 id_sel;

  assign id_sel = (ir_reg == JTAP_IR_IDCODE);

  // controller and shift paths advance on rising test clock
  always_comb begin
    state_next = state_reg;
    ir_next    = ir_reg;
    irsh_next  = irsh_reg;
    drsh_next  = drsh_reg;
    if (pins.trst_act) begin
      state_next = JTAP_TLR;
      ir_next    = JTAP_IR_IDCODE;
    end else if (pins.tck_rise) begin
      state_next = next_state(state_reg, pins.tms);
      unique case (state_reg)
        JTAP_TLR:       ir_next = JTAP_IR_IDCODE;
        JTAP_CAPT_IR:   irsh_next = JTAP_IR_CAPTURE;
        JTAP_SHIFT_IR:  irsh_next = {pins.tdi, irsh_reg[JTAP_IR_MSB:1]};
        JTAP_UPDATE_IR: ir_next = irsh_reg;
        JTAP_CAPT_DR:   drsh_next = id_sel ? JTAP_IDCODE_VAL : JTAP_DR_ZERO;
        JTAP_SHIFT_DR: begin
          // bypass is a single cell at bit zero; id shifts the full word
          if (id_sel) begin
            drsh_next = {pins.tdi, drsh_reg[JTAP_DR_MSB:1]};
          end else begin
            drsh_next = {drsh_reg[JTAP_DR_MSB:1], pins.tdi};
          end
        end
        default: ;
      endcase
    end
  end

  // output pin follows the falling test clock edge only; test reset releases it without one
  always_comb begin
    tdo_next = tdo_reg;
    oe_next  = oe_reg;
    tlr_next = (state_reg == JTAP_TLR);
    if (pins.trst_act) begin
      oe_next = 1'b0;
    end else if (pins.tck_fall) begin
      oe_next  = is_shift(state_reg);
      tdo_next = (state_reg == JTAP_SHIFT_IR) ? irsh_reg[0] : drsh_reg[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= JTAP_TLR;
      ir_reg    <= JTAP_IR_IDCODE;
      irsh_reg  <= JTAP_IR_ZERO;
      drsh_reg  <= JTAP_DR_ZERO;
      tdo_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      tlr_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      ir_reg    <= ir_next;
      irsh_reg  <= irsh_next;
      drsh_reg  <= drsh_next;
      tdo_reg   <= tdo_next;
      oe_reg    <= oe_next;
      tlr_reg   <= tlr_next;
    end
  end

  assign tdo       = tdo_reg;
  assign tdo_oe    = oe_reg;
  assign tlr_state = tlr_reg;

endmodule // jtap_tap

// file: jtap_tap_props.sv
// checker for the test access port pins
`timescale 1ns/1ps
module jtap_tap_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tlr_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] one_reg, one_next;
  logic       tck_reg, rise;
  // run of tms-high rises, saturating so it never wraps back to four
  always_comb begin
    rise     = tck & ~tck_reg;
    one_next = (!rst_n || (rise && !tms)) ? 3'h0 : one_reg + 3'(rise && one_reg != 3'h7);
  end
  always_ff @(posedge clk) begin
    tck_reg <= tck;
    one_reg <= one_next;
  end
  sequence s_fifth_one;
    rise && tms && one_reg == 3'h4;
  endsequence
  a_move_late: assert property (
    $changed({tdo, tdo_oe}) && trst_n |-> !tck && $past(!tck, 3)) else $error("tdo early");
  a_hold_high: assert property (tck && trst_n |=> $stable({tdo, tdo_oe}))
    else $error("tdo moved");
  a_reset_vals: assert property (disable iff (1'b0) !rst_n |=> !tdo_oe && tlr_state)
    else $error("reset values");
  a_trst_init: assert property (!trst_n [*6] |-> tlr_state && !tdo_oe)
    else $error("trst ignored");
  a_five_ones: assert property (s_fifth_one |-> ##[2:8] tlr_state)
    else $error("ones ignored");
  a_tlr_quiet: assert property (tlr_state |-> !tdo_oe)
    else $error("tdo driven");
  a_tlr_leave: assert property (tlr_state && rise && !tms && trst_n |-> ##[2:8] !tlr_state)
    else $error("reset kept");
  a_tlr_stay: assert property (tlr_state && rise && tms |=> tlr_state [*8])
    else $error("reset left");
endmodule // jtap_tap_props

bind jtap_tap jtap_tap_props jtap_tap_props_i (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
  .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .tlr_state(tlr_state));

// file: tb_jtap_tap_pin_interface.sv
// self-checking bench for the test access port
`timescale 1ns/1ps
module tb_jtap_tap_pin_interface;
  import jtap_pkg::*;
  localparam logic [31:0] PAT = 32'hA5C3_0F96;
  localparam logic [31:0] BYP = {PAT[30:0], 1'b0}; // bypass delays by one bit
  logic [3:0]  ir_row [4] = '{4'h1, 4'hF, 4'h0, 4'h7};
  logic [31:0] ex_row [4] = '{JTAP_IDCODE_VAL, BYP, BYP, BYP};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        q, o;
  logic [31:0] w;
  int          bad_count = 0;
  int          comparisons = 0;
  wire logic   tck, tms, tdi, trst_n, tdo, tdo_oe, tlr_state;
  always #2.5 clk = ~clk;
  jtap_tap jtap_tap_i (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .tlr_state(tlr_state));
  jtap_probe jtap_probe_i (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe));
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // walk n tms bits, lsb first
  task automatic go(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) jtap_probe_i.step(m[i], 1'b1, q, o);
  endtask
  // from a capture state: shift n bits, exit, update, idle
  task automatic scan(input logic [31:0] d, input int n, output logic [31:0] r);
    logic a;
    a = 1'b1;
    r = 32'h0;
    go(8'h00, 1);
    for (int i = 0; i < n; i++) begin
      jtap_probe_i.step(i == n - 1, d[i], q, o);
      r[i] = q;
      a &= o;
    end
    chk(32'h1, 32'(a));
    go(8'h01, 2);
    chk(32'h0, 32'(o));
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    #200_000 bad_count++;
    results;
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    #300 chk(32'h2, 32'({tlr_state, tdo_oe}));
    go(8'h00, 1);
    // rows: load an instruction, then scan the register it selects
    for (int k = 0; k < 4; k++) begin
      go(8'h03, 3);
      scan({28'h0, ir_row[k]}, 4, w);
      chk({28'h0, JTAP_IR_CAPTURE}, w);
      go(8'h01, 2);
      scan(PAT, 32, w);
      chk(ex_row[k], w);
      $display("row %0d done", k);
    end
    // five tms-high rises from inside shift-dr
    go(8'h01, 3);
    go(8'h1f, 5);
    chk(32'h1, 32'(tlr_state));
    // more mode-high rises must keep the controller in test-logic-reset
    go(8'h03, 2);
    chk(32'h1, 32'(tlr_state));
    $display("five ones done");
    // test reset with tck stopped in shift-dr
    go(8'h02, 4);
    #40 chk(32'h1, 32'(tdo_oe));
    jtap_probe_i.set_reset(1'b0);
    #50 chk(32'h2, 32'({tlr_state, tdo_oe}));
    jtap_probe_i.set_reset(1'b1);
    #50 go(8'h02, 3);
    scan(PAT, 32, w);
    chk(JTAP_IDCODE_VAL, w);
    $display("test reset done");
    // id word split by exit1, pause, exit2 and back to shift
    go(8'h01, 2);
    go(8'h00, 1);
    for (int i = 0; i < 32; i++) begin
      jtap_probe_i.step(i == 15 || i == 31, 1'b0, q, o);
      w[i] = q;
      if (i == 15) begin
        go(8'h02, 3);
        chk(32'h0, 32'(o));
      end
    end
    go(8'h01, 2);
    chk(JTAP_IDCODE_VAL, w);
    $display("pause done");
    results;
  end
endmodule // tb_jtap_tap_pin_interface
